// ==== dv/ldsip_port_monitor.sv ====
// assertion checker for the ddr sample input port
`timescale 1ns/10ps
`default_nettype none
module ldsip_port_monitor #(
   parameter PW = 16
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sample_bus_clock_pair,
   input wire logic input_strobe_or_first_parity,
   input wire logic rev_interface,
   input wire logic [1:0] strobe_mode,
   input wire logic dual_sync_mode,
   input wire logic parity_clear,
   input wire logic word_ready,
   input wire logic word_valid,
   input wire logic [4*PW-1:0] word_data,
   input wire logic fifo_align,
   input wire logic sync_pulse,
   input wire logic out_align,
   input wire logic parity_err,
   input wire logic pattern_err
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_fifo;
      $rose(sample_bus_clock_pair) && input_strobe_or_first_parity && !rev_interface && strobe_mode == 2'h0
         |-> ##[1:8] fifo_align;
   endproperty
   a_fifo: assert property (p_fifo) else $error("strobe gave no fifo align");
   property p_sync;
      $rose(sample_bus_clock_pair) && input_strobe_or_first_parity && !rev_interface && strobe_mode == 2'h1
         |-> ##[1:8] sync_pulse;
   endproperty
   a_sync: assert property (p_sync) else $error("strobe gave no sync pulse");
   property p_fonly;
      fifo_align |-> strobe_mode == 2'h0;
   endproperty
   a_fonly: assert property (p_fonly) else $error("fifo align in wrong mode");
   property p_sonly;
      sync_pulse |-> strobe_mode == 2'h1;
   endproperty
   a_sonly: assert property (p_sonly) else $error("sync pulse in wrong mode");
   property p_oonly;
      out_align |-> dual_sync_mode;
   endproperty
   a_oonly: assert property (p_oonly) else $error("out align without dual sync");
   property p_hold;
      word_valid && !word_ready |=> word_valid && $stable(word_data);
   endproperty
   a_hold: assert property (p_hold) else $error("word dropped while stalled");
   property p_perr;
      parity_err && !parity_clear |=> parity_err;
   endproperty
   a_perr: assert property (p_perr) else $error("parity error not sticky");
   property p_pat;
      pattern_err |=> pattern_err;
   endproperty
   a_pat: assert property (p_pat) else $error("pattern error not sticky");
endmodule // ldsip_port_monitor
bind ldsip_port ldsip_port_monitor #(.PW(PW)) u_mon (.core_clk, .rst_n, .sample_bus_clock_pair,
   .input_strobe_or_first_parity, .rev_interface, .strobe_mode, .dual_sync_mode, .parity_clear, .word_ready,
   .word_valid, .word_data, .fifo_align, .sync_pulse, .out_align, .parity_err, .pattern_err);
`default_nettype wire

// ==== dv/ldsip_src.sv ====
// data source model driving the ddr sample bus
`timescale 1ns/10ps
`default_nettype none
module ldsip_src (
   input wire logic core_clk,
   output logic dclk,
   output logic [15:0] ab,
   output logic [15:0] cd,
   output logic strb,
   output logic par2
);
   initial {dclk, ab, cd, strb, par2} = 35'h0;
   // one word, two core cycles a half, ab and cd inverted after (strb and par2 keep their fall values)
   task send(input [15:0] ar, af, cr, cf, input s, p);
      @(posedge core_clk);
      {dclk, ab, cd, strb, par2} <= {1'b1, ar, cr, s, p};
      repeat (2) @(posedge core_clk);
      {dclk, ab, cd, strb, par2} <= {1'b0, af, cf, ~s, ~p};
      repeat (2) @(posedge core_clk);
      {ab, cd} <= ~{af, cf};
   endtask
endmodule // ldsip_src
`default_nettype wire

// ==== dv/tb_lvds_ddr_sample_input_port.sv ====
// self-checking bench for the ddr sample input port
`timescale 1ns/10ps
`default_nettype none
module tb_lvds_ddr_sample_input_port;
   logic core_clk, rst_n, sample_bus_clock_pair, input_strobe_or_first_parity, second_path_parity, sync_input;
   logic output_strobe, converter_clock, rev_bus, rev_interface, dual_sync_mode, parity_odd, parity_cd_ena;
   logic parity_clear, pattern_ena, word_ready, word_valid, fifo_align, sync_pulse, out_align;
   logic parity_err, pattern_err, overrun;
   logic [15:0] first_path_sample_bus, second_path_sample_bus;
   logic [1:0] strobe_mode;
   logic [63:0] word_data;
   logic [7:0] n_fa = 8'h00, n_sy = 8'h00, n_oa = 8'h00;
   int bad_count = 0, checks = 0;
   ldsip_port u_dut (.core_clk, .rst_n, .sample_bus_clock_pair, .first_path_sample_bus, .second_path_sample_bus,
      .input_strobe_or_first_parity, .second_path_parity, .sync_input, .output_strobe, .converter_clock, .rev_bus,
      .rev_interface, .strobe_mode, .dual_sync_mode, .parity_odd, .parity_cd_ena, .parity_clear, .pattern_ena,
      .word_ready, .word_valid, .word_data, .fifo_align, .sync_pulse, .out_align, .parity_err, .pattern_err, .overrun);
   ldsip_src u_src (.core_clk, .dclk(sample_bus_clock_pair), .ab(first_path_sample_bus),
      .cd(second_path_sample_bus), .strb(input_strobe_or_first_parity), .par2(second_path_parity));
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      n_fa <= n_fa + {7'h00, fifo_align};
      n_sy <= n_sy + {7'h00, sync_pulse};
      n_oa <= n_oa + {7'h00, out_align};
   end
   task chk(input [63:0] got, input [63:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      if (bad_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task take(input [63:0] exp);
      int i;
      for (i = 0; i < 40; i++) begin
         @(posedge core_clk);
         if (word_valid === 1'b1 && word_ready === 1'b1) break;
      end
      if (i == 40) begin
         bad_count = bad_count + 1;
         test_done;
      end else
         chk(word_data, exp);
   endtask
   task one(input s, input p);
      u_src.send(16'h0000, 16'h0000, 16'h0000, 16'h0000, s, p);
      take(64'h0);
      repeat (2) @(posedge core_clk);
   endtask
   task clr;
      parity_clear <= 1'b1;
      @(posedge core_clk);
      parity_clear <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(parity_err, 0);
      chk(overrun, 0);
   endtask
   task t_order;
      u_src.send(16'h8001, 16'h1234, 16'hc003, 16'h00f0, 1'b0, 1'b0);
      take(64'h8001_1234_c003_00f0);
      rev_bus <= 1'b1;
      u_src.send(16'h8001, 16'h1234, 16'hc003, 16'h00f0, 1'b0, 1'b0);
      take(64'h8001_2c48_c003_0f00);
      rev_bus <= 1'b0;
   endtask
   task t_modes;
      one(1'b1, 1'b0);
      chk(n_fa, 1);
      strobe_mode <= 2'h1;
      one(1'b1, 1'b0);
      chk(n_sy, 1);
      strobe_mode <= 2'h0;
      rev_interface <= 1'b1;
      one(1'b0, 1'b1);
      chk(n_fa, 2);
      strobe_mode <= 2'h2;
      rev_interface <= 1'b0;
      parity_odd <= 1'b1;
      one(1'b1, 1'b0);
      chk(parity_err, 0);
      parity_odd <= 1'b0;
      one(1'b1, 1'b0);
      chk(parity_err, 1);
      clr;
      rev_interface <= 1'b1;
      one(1'b0, 1'b1);
      chk(parity_err, 1);
      clr;
      rev_interface <= 1'b0;
      parity_cd_ena <= 1'b1;
      one(1'b0, 1'b1);
      chk(parity_err, 1);
      clr;
      parity_cd_ena <= 1'b0;
      strobe_mode <= 2'h0;
   endtask
   task t_buf_out;
      int i;
      word_ready <= 1'b0;
      for (i = 1; i < 5; i++) u_src.send(i[15:0], i[15:0], i[15:0], i[15:0], 1'b0, 1'b0);
      @(posedge core_clk);
      chk(overrun, 1);
      word_ready <= 1'b1;
      take({4{16'h0001}});
      take({4{16'h0002}});
      take({4{16'h0003}});
      repeat (4) @(posedge core_clk);
      chk(word_valid, 0);
      clr;
      dual_sync_mode <= 1'b1;
      for (i = 0; i < 3; i++) begin
         converter_clock <= 1'b1;
         output_strobe <= (i == 1);
         repeat (2) @(posedge core_clk);
         converter_clock <= 1'b0;
         output_strobe <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
      chk(n_oa, 1);
      pattern_ena <= 1'b1;
      one(1'b0, 1'b0);
      chk(pattern_err, 1);
   endtask
   initial begin
      {core_clk, rst_n, sync_input, output_strobe, converter_clock, rev_bus, rev_interface} = 7'h00;
      {dual_sync_mode, parity_odd, parity_cd_ena, parity_clear, pattern_ena, strobe_mode} = 7'h00;
      word_ready = 1'b1;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      t_order;
      t_modes;
      t_buf_out;
      test_done;
   end
endmodule // tb_lvds_ddr_sample_input_port
`default_nettype wire

// ==== src/ldsip_consts.vh ====
// constants for the ddr sample input port
`ifndef LDSIP_CONSTS_VH
`define LDSIP_CONSTS_VH
`define LDSIP_PATH_W 16
`define LDSIP_WORD_W 64
`define LDSIP_STRB_FIFO 2'h0
`define LDSIP_STRB_SYNC 2'h1
`define LDSIP_STRB_PARITY 2'h2
`define LDSIP_MAX_MSPS 750
`define LDSIP_CLK_MHZ 50
`define LDSIP_PTR_RST 3'h0
`define LDSIP_PRBS_SEED 16'h0001
`endif

// ==== src/ldsip_port.v ====
// ddr sample input port: capture, reorder, strobe handling, checks
`timescale 1ns/10ps
`default_nettype none
`include "ldsip_consts.vh"
module ldsip_port #(
   parameter PW = `LDSIP_PATH_W
) (
   input wire core_clk,
   input wire rst_n,
   input wire sample_bus_clock_pair,
   input wire [PW-1:0] first_path_sample_bus,
   input wire [PW-1:0] second_path_sample_bus,
   input wire input_strobe_or_first_parity,
   input wire second_path_parity,
   input wire sync_input,
   input wire output_strobe,
   input wire converter_clock,
   input wire rev_bus,
   input wire rev_interface,
   input wire [1:0] strobe_mode,
   input wire dual_sync_mode,
   input wire parity_odd,
   input wire parity_cd_ena,
   input wire parity_clear,
   input wire pattern_ena,
   input wire word_ready,
   output reg word_valid,
   output reg [4*PW-1:0] word_data,
   output reg fifo_align,
   output reg sync_pulse,
   output reg out_align,
   output reg parity_err,
   output reg pattern_err,
   output reg overrun
);
   localparam WW = 4*PW;
   localparam PH_RISE = 1'b0;
   localparam PH_FALL = 1'b1;
   reg dclk_q_reg;
   reg cclk_q_reg;
   reg phase_reg;
   reg [PW-1:0] ab_rise_reg;
   reg [PW-1:0] cd_rise_reg;
   reg strb_reg;
   reg par_cd_reg;
   reg [2:0] wptr_reg;
   reg [PW-1:0] prbs_reg;
   reg [WW-1:0] cap_word_reg;
   reg cap_valid_reg;
   reg cap_strb_reg;
   reg cap_pcd_reg;
   wire dclk_rise;
   wire dclk_fall;
   wire cclk_rise;
   wire [PW-1:0] ab_in;
   wire [PW-1:0] cd_in;
   wire strb_pin;
   wire pcd_pin;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [WW-1:0] buf_out_data;
   wire ab_par_calc;
   wire cd_par_calc;
   wire ab_par_bad;
   wire cd_par_bad;
   wire [PW-1:0] prbs_next;
   // ************************************************************
   // bit reordering
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < PW; gi = gi + 1) begin : g_rev
         assign ab_in[gi] = rev_bus ? first_path_sample_bus[PW-1-gi] : first_path_sample_bus[gi];
         assign cd_in[gi] = rev_bus ? second_path_sample_bus[PW-1-gi] : second_path_sample_bus[gi];
      end
   endgenerate
   // ************************************************************
   // strobe and parity pin mapping
   // ************************************************************
   // mirrored interface swaps strobe and second parity pins
   assign strb_pin = rev_interface ? second_path_parity : input_strobe_or_first_parity;
   assign pcd_pin = rev_interface ? input_strobe_or_first_parity : second_path_parity;
   // ************************************************************
   // edge detection
   // ************************************************************
   // delayed copies reset low, matching the idle pins, so no false edge
   assign dclk_rise = sample_bus_clock_pair & ~dclk_q_reg;
   assign dclk_fall = ~sample_bus_clock_pair & dclk_q_reg;
   assign cclk_rise = converter_clock & ~cclk_q_reg;
   // ************************************************************
   // ddr capture
   // ************************************************************
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dclk_q_reg <= 1'b0;
         cclk_q_reg <= 1'b0;
         phase_reg <= PH_RISE;
         ab_rise_reg <= {PW{1'b0}};
         cd_rise_reg <= {PW{1'b0}};
         strb_reg <= 1'b0;
         par_cd_reg <= 1'b0;
         cap_word_reg <= {WW{1'b0}};
         cap_valid_reg <= 1'b0;
         cap_strb_reg <= 1'b0;
         cap_pcd_reg <= 1'b0;
      end else begin
         dclk_q_reg <= sample_bus_clock_pair;
         cclk_q_reg <= converter_clock;
         cap_valid_reg <= 1'b0;
         if (dclk_rise) begin
            ab_rise_reg <= ab_in;
            cd_rise_reg <= cd_in;
            strb_reg <= strb_pin;
            par_cd_reg <= pcd_pin;
            phase_reg <= PH_FALL;
         end
         if (dclk_fall && phase_reg == PH_FALL) begin
            // word: ab rise, ab fall, cd rise, cd fall, msb first
            cap_word_reg <= {ab_rise_reg, ab_in, cd_rise_reg, cd_in};
            cap_valid_reg <= 1'b1;
            cap_strb_reg <= strb_reg;
            cap_pcd_reg <= par_cd_reg;
            phase_reg <= PH_RISE;
         end
      end
   end
   // ************************************************************
   // buffer
   // ************************************************************
   ldsip_skid #(
      .W(WW)
   ) u_skid (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(cap_valid_reg),
      .in_ready(buf_in_ready),
      .in_data(cap_word_reg),
      .out_valid(buf_out_valid),
      .out_ready(~word_valid | word_ready),
      .out_data(buf_out_data)
   );
   // ************************************************************
   // checks
   // ************************************************************
   assign ab_par_calc = ^cap_word_reg[WW-1:2*PW] ^ parity_odd;
   assign cd_par_calc = ^cap_word_reg[2*PW-1:0] ^ parity_odd;
   assign ab_par_bad = (strobe_mode == `LDSIP_STRB_PARITY) && (ab_par_calc != cap_strb_reg);
   assign cd_par_bad = parity_cd_ena && (cd_par_calc != cap_pcd_reg);
   assign prbs_next = {prbs_reg[PW-2:0], prbs_reg[PW-1] ^ prbs_reg[PW-3]};
   // ************************************************************
   // output register and strobe pulses
   // ************************************************************
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_valid <= 1'b0;
         word_data <= {WW{1'b0}};
         fifo_align <= 1'b0;
         sync_pulse <= 1'b0;
         out_align <= 1'b0;
         wptr_reg <= `LDSIP_PTR_RST;
      end else begin
         if (buf_out_valid & (~word_valid | word_ready)) begin
            word_valid <= 1'b1;
            word_data <= buf_out_data;
         end else if (word_ready)
            word_valid <= 1'b0;
         fifo_align <= 1'b0;
         sync_pulse <= 1'b0;
         out_align <= dual_sync_mode & cclk_rise & output_strobe;
         if (cap_valid_reg) begin
            wptr_reg <= wptr_reg + 3'h1;
            if (cap_strb_reg && strobe_mode == `LDSIP_STRB_FIFO) begin
               wptr_reg <= `LDSIP_PTR_RST;
               fifo_align <= 1'b1;
            end
            if (cap_strb_reg && strobe_mode == `LDSIP_STRB_SYNC)
               sync_pulse <= 1'b1;
         end
      end
   end
   // ************************************************************
   // sticky error flags
   // ************************************************************
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         parity_err <= 1'b0;
         pattern_err <= 1'b0;
         overrun <= 1'b0;
         prbs_reg <= `LDSIP_PRBS_SEED;
      end else begin
         // pattern checker steps once per captured word
         if (cap_valid_reg && pattern_ena) begin
            prbs_reg <= prbs_next;
            if (cap_word_reg[PW-1:0] != prbs_reg)
               pattern_err <= 1'b1;
         end
         // a new error wins over a clear in the same cycle
         if (cap_valid_reg && (ab_par_bad || cd_par_bad))
            parity_err <= 1'b1;
         else if (parity_clear)
            parity_err <= 1'b0;
         // a source faster than the sink drains loses words here
         if (cap_valid_reg & ~buf_in_ready)
            overrun <= 1'b1;
         else if (parity_clear)
            overrun <= 1'b0;
      end
   end
endmodule // ldsip_port
`default_nettype wire

// ==== src/ldsip_skid.v ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module ldsip_skid #(
   parameter W = 64
) (
   input wire core_clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem_reg [0:1];
   reg wr_ptr_reg;
   reg rd_ptr_reg;
   reg [1:0] cnt_reg;
   wire push;
   wire pop;
   assign in_ready = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         cnt_reg <= 2'h0;
         mem_reg[0] <= {W{1'b0}};
         mem_reg[1] <= {W{1'b0}};
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         if (push & ~pop)
            cnt_reg <= cnt_reg + 2'h1;
         else if (pop & ~push)
            cnt_reg <= cnt_reg - 2'h1;
      end
   end
endmodule // ldsip_skid
`default_nettype wire
